// ==== verilog/pcus_pkg.sv ====
// package: register map, field positions, reset values and timing for the startup block
package pcus_pkg;
    localparam int WORD_W = 32;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 8;
    localparam int BIT_CNT_W = 5;
    localparam int STARTUP_CNT_W = 4;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONST = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_WORD = 8'h0C;

    localparam int CTRL_CONST_BIT = 0;
    localparam int STATUS_EOS_BIT = 0;
    localparam int STATUS_STREAM_BIT = 1;
    localparam int STATUS_CNT_LSB = 8;

    localparam logic [WORD_W-1:0] CONST_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] WORD_INIT = 32'h0000_0000;
    localparam logic [WORD_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 5'h1F;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    localparam int CLK_PERIOD_NS = 50;
    localparam int STARTUP_TIME_NS = 400;
    localparam int STARTUP_CYCLES_INT = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST =
        STARTUP_CNT_W'(STARTUP_CYCLES_INT - 1);
    localparam logic [STARTUP_CNT_W-1:0] STARTUP_ONE = 4'h1;

    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_USER = 2'b01
    } pcus_state_e;

    function automatic logic pcus_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] reg_addr);
        pcus_hit = (addr == reg_addr);
    endfunction : pcus_hit
endpackage : pcus_pkg

// ==== verilog/pcus_uar.sv ====
// user access register: shifts bitstream words in on the link clock and flags each new word
module pcus_uar
    import pcus_pkg::*;
(
    input wire logic link_clk_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic serial_data_in,
    output logic [WORD_W-1:0] word_out,
    output logic valid_out,
    output logic toggle_out
);
    logic rst_meta_n;
    logic link_rst_n;
    logic [WORD_W-1:0] shift;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [WORD_W-1:0] next_shift;
    logic [BIT_CNT_W-1:0] next_bit_cnt;
    logic [WORD_W-1:0] next_word_out;
    logic next_valid_out;
    logic next_toggle_out;

    // reset released on the link clock so the first frame edge sees a clean state
    always_ff @(posedge link_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_n <= 1'b0;
            link_rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            link_rst_n <= rst_meta_n;
        end
    end

    always_comb begin
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_word_out = word_out;
        next_valid_out = 1'b0;
        next_toggle_out = toggle_out;
        if (load_in) begin
            next_shift = {shift[WORD_W-2:0], serial_data_in};
            next_bit_cnt = bit_cnt + BIT_CNT_W'(1);
            if (bit_cnt == BIT_LAST) begin
                next_word_out = {shift[WORD_W-2:0], serial_data_in};
                next_valid_out = 1'b1;
                next_toggle_out = ~toggle_out;
                next_bit_cnt = BIT_FIRST;
            end
        end else begin
            // a broken frame never leaves a half word behind
            next_bit_cnt = BIT_FIRST;
        end
    end

    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift <= WORD_INIT;
            bit_cnt <= BIT_FIRST;
            word_out <= WORD_INIT;
            valid_out <= 1'b0;
            toggle_out <= 1'b0;
        end else begin
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            word_out <= next_word_out;
            valid_out <= next_valid_out;
            toggle_out <= next_toggle_out;
        end
    end
endmodule : pcus_uar

// ==== verilog/pcus_top.sv ====
// top: user access register, startup control, pin overrides and config clock taps
//
// The address-and-strobe port and the register addresses were left to the implementer.
module pcus_top
    import pcus_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic cfg_link_clk_in,
    input wire logic cfg_oscillator_clock_in,
    input wire logic link_load_in,
    input wire logic link_serial_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [WORD_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [WORD_W-1:0] reg_rdata_out,
    input wire logic global_set_reset_in,
    input wire logic global_tristate_in,
    input wire logic user_cfg_clock_out_in,
    input wire logic user_cfg_clock_tristate_in,
    input wire logic user_done_out_in,
    input wire logic user_done_tristate_in,
    input wire logic test_clock_pin_in,
    input wire logic serial_data_pin_in,
    output logic end_of_startup_out,
    output logic [WORD_W-1:0] user_data_out,
    output logic user_data_valid_out,
    output logic ua_cfg_clock_out,
    output logic [WORD_W-1:0] fabric_word_out,
    output logic global_set_reset_out,
    output logic global_tristate_out,
    output logic configuration_clock_pin_out,
    output logic configuration_clock_pin_oe_n_out,
    output logic done_pin_out,
    output logic done_pin_oe_n_out,
    output logic test_clock_tap_out,
    output logic serial_in_tap_out,
    output logic cfg_oscillator_clock_out,
    output logic cfg_main_clock_out
);
    logic rst_meta_n;
    logic rst_n;
    logic [WORD_W-1:0] link_word;
    logic link_valid;
    logic link_toggle;

    // clock taps cannot come from a flop without halving them, so they pass straight out
    assign ua_cfg_clock_out = cfg_link_clk_in;
    assign cfg_oscillator_clock_out = cfg_oscillator_clock_in;
    assign cfg_main_clock_out = mclk_in;
    assign user_data_out = link_word;
    assign user_data_valid_out = link_valid;

    pcus_uar u_uar (
        .link_clk_in(cfg_link_clk_in),
        .resetn_in(resetn_in),
        .load_in(link_load_in),
        .serial_data_in(link_serial_in),
        .word_out(link_word),
        .valid_out(link_valid),
        .toggle_out(link_toggle)
    );

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // crossing and pin synchronisers: first stage feeds only the second
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic tck_meta;
    logic tck_sync;
    logic din_meta;
    logic din_sync;
    logic next_tog_seen;
    logic next_tog_meta;
    logic next_tog_sync;
    logic next_tck_meta;
    logic next_tck_sync;
    logic next_din_meta;
    logic next_din_sync;

    // only the toggle crosses; the word itself is read once the toggle has settled
    always_comb begin
        next_tog_meta = link_toggle;
        next_tog_sync = tog_meta;
        next_tog_seen = tog_sync;
        next_tck_meta = test_clock_pin_in;
        next_tck_sync = tck_meta;
        next_din_meta = serial_data_pin_in;
        next_din_sync = din_meta;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
            tck_meta <= 1'b0;
            tck_sync <= 1'b0;
            din_meta <= 1'b0;
            din_sync <= 1'b0;
        end else if (ce_in) begin
            tog_meta <= next_tog_meta;
            tog_sync <= next_tog_sync;
            tog_seen <= next_tog_seen;
            tck_meta <= next_tck_meta;
            tck_sync <= next_tck_sync;
            din_meta <= next_din_meta;
            din_sync <= next_din_sync;
        end
    end

    // one event per toggle, so a stalled link clock never repeats a word
    wire logic word_event = tog_sync ^ tog_seen;

    // startup sequencer and pin control
    pcus_state_e state;
    pcus_state_e next_state;
    logic [STARTUP_CNT_W-1:0] su_cnt;
    logic [STARTUP_CNT_W-1:0] next_su_cnt;
    logic own_clk;
    logic next_own_clk;
    logic next_eos;
    logic next_configuration_clock_pin;
    logic next_configuration_clock_pin_oe_n;
    logic next_done;
    logic next_done_oe_n;
    logic next_gsr;
    logic next_gts;
    logic next_tck_tap;
    logic next_din_tap;

    always_comb begin
        next_state = state;
        next_su_cnt = su_cnt;
        next_own_clk = ~own_clk;
        next_eos = 1'b0;
        // before end of startup the device runs the clock pin and holds done low
        next_configuration_clock_pin = own_clk;
        next_configuration_clock_pin_oe_n = 1'b0;
        next_done = 1'b0;
        next_done_oe_n = 1'b0;
        case (state)
            ST_STARTUP: begin
                next_su_cnt = su_cnt + STARTUP_ONE;
                if (su_cnt == STARTUP_LAST) begin
                    next_state = ST_USER;
                    next_eos = 1'b1;
                end
            end
            ST_USER: begin
                next_eos = 1'b1;
                next_configuration_clock_pin = user_cfg_clock_out_in;
                next_configuration_clock_pin_oe_n = user_cfg_clock_tristate_in;
                next_done = user_done_out_in;
                next_done_oe_n = user_done_tristate_in;
            end
            default: begin
                next_state = ST_STARTUP;
                next_su_cnt = '0;
            end
        endcase
        next_gsr = global_set_reset_in;
        next_gts = global_tristate_in;
        next_tck_tap = tck_sync;
        next_din_tap = din_sync;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_STARTUP;
            su_cnt <= '0;
            own_clk <= 1'b0;
            end_of_startup_out <= 1'b0;
            configuration_clock_pin_out <= 1'b0;
            configuration_clock_pin_oe_n_out <= 1'b0;
            done_pin_out <= 1'b0;
            done_pin_oe_n_out <= 1'b0;
            global_set_reset_out <= 1'b0;
            global_tristate_out <= 1'b0;
            test_clock_tap_out <= 1'b0;
            serial_in_tap_out <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            su_cnt <= next_su_cnt;
            own_clk <= next_own_clk;
            end_of_startup_out <= next_eos;
            configuration_clock_pin_out <= next_configuration_clock_pin;
            configuration_clock_pin_oe_n_out <= next_configuration_clock_pin_oe_n;
            done_pin_out <= next_done;
            done_pin_oe_n_out <= next_done_oe_n;
            global_set_reset_out <= next_gsr;
            global_tristate_out <= next_gts;
            test_clock_tap_out <= next_tck_tap;
            serial_in_tap_out <= next_din_tap;
        end
    end

    // register file and fabric word
    logic const_mode;
    logic [WORD_W-1:0] const_word;
    logic [WORD_W-1:0] last_word;
    logic stream_seen;
    logic [CNT_W-1:0] word_cnt;
    logic next_const_mode;
    logic [WORD_W-1:0] next_const_word;
    logic [WORD_W-1:0] next_last_word;
    logic next_stream_seen;
    logic [CNT_W-1:0] next_word_cnt;
    logic [WORD_W-1:0] next_rdata;
    logic [WORD_W-1:0] next_fabric_word;

    always_comb begin
        next_const_mode = const_mode;
        next_const_word = const_word;
        next_last_word = last_word;
        next_stream_seen = stream_seen;
        next_word_cnt = word_cnt;
        next_rdata = READ_ZERO;
        if (reg_wr_in) begin
            if (pcus_hit(reg_addr_in, ADDR_CTRL)) begin
                next_const_mode = reg_wdata_in[CTRL_CONST_BIT];
            end else if (pcus_hit(reg_addr_in, ADDR_CONST)) begin
                next_const_word = reg_wdata_in;
            end else if (pcus_hit(reg_addr_in, ADDR_STATUS)) begin
                next_stream_seen = 1'b0;
            end
        end
        // a new word in the clearing cycle keeps the flag set
        if (word_event) begin
            next_last_word = link_word; // word is stable for a whole frame after the toggle
            next_stream_seen = 1'b1;
            next_word_cnt = word_cnt + CNT_ONE;
        end
        if (reg_rd_in) begin
            if (pcus_hit(reg_addr_in, ADDR_CTRL)) begin
                next_rdata[CTRL_CONST_BIT] = const_mode;
            end else if (pcus_hit(reg_addr_in, ADDR_CONST)) begin
                next_rdata = const_word;
            end else if (pcus_hit(reg_addr_in, ADDR_STATUS)) begin
                next_rdata[STATUS_EOS_BIT] = end_of_startup_out;
                next_rdata[STATUS_STREAM_BIT] = stream_seen;
                next_rdata[STATUS_CNT_LSB +: CNT_W] = word_cnt;
            end else if (pcus_hit(reg_addr_in, ADDR_WORD)) begin
                next_rdata = last_word;
            end
        end
        next_fabric_word = next_const_mode ? next_const_word : next_last_word;
        if (global_set_reset_in) begin
            // only the data path returns to its initial value; software settings survive
            next_last_word = WORD_INIT;
            next_fabric_word = WORD_INIT;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            const_mode <= 1'b0;
            const_word <= CONST_RESET;
            last_word <= WORD_INIT;
            stream_seen <= 1'b0;
            word_cnt <= '0;
            reg_rdata_out <= READ_ZERO;
            fabric_word_out <= WORD_INIT;
        end else if (ce_in) begin
            const_mode <= next_const_mode;
            const_word <= next_const_word;
            last_word <= next_last_word;
            stream_seen <= next_stream_seen;
            word_cnt <= next_word_cnt;
            reg_rdata_out <= next_rdata;
            fabric_word_out <= next_fabric_word;
        end
    end
endmodule : pcus_top

// ==== tb/pcus_top_assertions.sv ====
// checker: port timing of the startup block
module pcus_top_assertions
    import pcus_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic cfg_link_clk_in,
    input wire logic link_load_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [WORD_W-1:0] reg_rdata_out,
    input wire logic global_set_reset_in,
    input wire logic user_cfg_clock_out_in,
    input wire logic user_cfg_clock_tristate_in,
    input wire logic user_done_out_in,
    input wire logic user_done_tristate_in,
    input wire logic test_clock_pin_in,
    input wire logic end_of_startup_out,
    input wire logic user_data_valid_out,
    input wire logic [WORD_W-1:0] fabric_word_out,
    input wire logic global_set_reset_out,
    input wire logic configuration_clock_pin_out,
    input wire logic configuration_clock_pin_oe_n_out,
    input wire logic done_pin_out,
    input wire logic done_pin_oe_n_out,
    input wire logic test_clock_tap_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // overrides and taps freeze while the clock enable is low
    sequence s_owned;
        $past(ce_in) && $past(ce_in, 2) && $past(ce_in, 3) && $past(end_of_startup_out, 2);
    endsequence
    a_eos_holds: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        end_of_startup_out |=> end_of_startup_out) else $error("end of startup fell");
    a_pins_kept: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        !end_of_startup_out |-> !done_pin_out && !done_pin_oe_n_out
        && !configuration_clock_pin_oe_n_out) else $error("pins released early");
    a_clk_follow: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        s_owned |-> configuration_clock_pin_out == $past(user_cfg_clock_out_in)
        && configuration_clock_pin_oe_n_out == $past(user_cfg_clock_tristate_in))
        else $error("clock pin override wrong");
    a_done_follow: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        s_owned |-> done_pin_out == $past(user_done_out_in)
        && done_pin_oe_n_out == $past(user_done_tristate_in)) else $error("done override wrong");
    a_gsr_clear: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && global_set_reset_in) [*2] |=> fabric_word_out == WORD_INIT
        && global_set_reset_out) else $error("set/reset did not clear");
    a_rd_eos: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        reg_rd_in && ce_in && reg_addr_in == ADDR_STATUS |=>
        reg_rdata_out[STATUS_EOS_BIT] == $past(end_of_startup_out)) else $error("status eos");
    a_tap_delay: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        s_owned |-> test_clock_tap_out == $past(test_clock_pin_in, 3)) else $error("tap delay");
    a_valid_pulse: assert property (@(posedge cfg_link_clk_in) disable iff (!resetn_in)
        user_data_valid_out |-> $past(link_load_in) ##1 !user_data_valid_out)
        else $error("valid not one cycle");
endmodule : pcus_top_assertions

bind pcus_top pcus_top_assertions u_chk (.mclk_in, .resetn_in, .ce_in, .cfg_link_clk_in,
    .link_load_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .global_set_reset_in,
    .user_cfg_clock_out_in, .user_cfg_clock_tristate_in, .user_done_out_in,
    .user_done_tristate_in, .test_clock_pin_in, .end_of_startup_out, .user_data_valid_out,
    .fabric_word_out, .global_set_reset_out, .configuration_clock_pin_out,
    .configuration_clock_pin_oe_n_out, .done_pin_out, .done_pin_oe_n_out, .test_clock_tap_out);

// ==== tb/pcus_prom_model.sv ====
// far side: clocks stream words into the user access register, msb first
module pcus_prom_model
    import pcus_pkg::*;
(
    output logic link_clk_out,
    output logic load_out,
    output logic serial_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk_out = 1'b0;
        load_out = 1'b0;
        serial_out = 1'b1;
    end
    // a controlled clock: it only runs while send or tail drive it, with load high or low
    task automatic edge_once();
        #40 link_clk_out = 1'b1;
        #40 link_clk_out = 1'b0;
    endtask : edge_once
    task automatic tail(input int n);
        load_out = 1'b0;
        serial_out = ~serial_out;
        repeat (n) edge_once();
    endtask : tail
    task automatic send(input logic [WORD_W-1:0] w, input int nbits);
        for (int i = WORD_W - 1; i >= WORD_W - nbits; i--) begin
            load_out = 1'b1;
            serial_out = w[i];
            edge_once();
        end
    endtask : send
endmodule : pcus_prom_model

// ==== tb/tb.sv ====
// bench: drives the startup block and checks it against a queue of expected words
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb
    import pcus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 0, resetn_in = 0, ce_in = 1, cfg_oscillator_clock_in = 0;
    logic cfg_link_clk_in, link_load_in, link_serial_in, reg_wr_in = 0, reg_rd_in = 0;
    logic [ADDR_W-1:0] reg_addr_in = 0;
    logic [WORD_W-1:0] reg_wdata_in = 0, reg_rdata_out, user_data_out, fabric_word_out;
    logic [WORD_W-1:0] konst, w, lw, exp_q[$];
    logic global_set_reset_in = 0, global_tristate_in = 0, user_cfg_clock_out_in = 0;
    logic user_cfg_clock_tristate_in = 0, user_done_out_in = 0, user_done_tristate_in = 0;
    logic test_clock_pin_in = 0, serial_data_pin_in = 0, end_of_startup_out;
    logic user_data_valid_out, ua_cfg_clock_out, global_set_reset_out, global_tristate_out;
    logic configuration_clock_pin_out, configuration_clock_pin_oe_n_out, done_pin_out;
    logic done_pin_oe_n_out, test_clock_tap_out, serial_in_tap_out;
    logic cfg_oscillator_clock_out, cfg_main_clock_out;
    int errors = 0, num_checks = 0, n;
    pcus_top DUT (.mclk_in, .resetn_in, .ce_in, .cfg_link_clk_in, .cfg_oscillator_clock_in,
        .link_load_in, .link_serial_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .global_set_reset_in, .global_tristate_in, .user_cfg_clock_out_in,
        .user_cfg_clock_tristate_in, .user_done_out_in, .user_done_tristate_in,
        .test_clock_pin_in, .serial_data_pin_in, .end_of_startup_out, .user_data_out,
        .user_data_valid_out, .ua_cfg_clock_out, .fabric_word_out, .global_set_reset_out,
        .global_tristate_out, .configuration_clock_pin_out, .configuration_clock_pin_oe_n_out,
        .done_pin_out, .done_pin_oe_n_out, .test_clock_tap_out, .serial_in_tap_out,
        .cfg_oscillator_clock_out, .cfg_main_clock_out);
    pcus_prom_model prom (.link_clk_out(cfg_link_clk_in), .load_out(link_load_in),
        .serial_out(link_serial_in));
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    always #10 cfg_oscillator_clock_in = ~cfg_oscillator_clock_in;
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // one task for both strobes; a read compares the word one cycle later
    task automatic acc(input logic wen, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= wen;
        reg_rd_in <= !wen;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        if (!wen) begin
            #1 `CHK(reg_rdata_out, d)
        end
    endtask : acc
    always @(posedge cfg_link_clk_in) begin
        #2 `CHK(ua_cfg_clock_out, 1'b1)
        if (user_data_valid_out === 1'b1) begin
            lw = exp_q.pop_front();
            `CHK(user_data_out, lw)
        end
    end
    initial begin
        #200000;
        errors++;
        complete_run();
    end
    initial begin
        n = $urandom(37);
        repeat (2) @(posedge mclk_in);
        resetn_in <= 1'b1;
        n = 0;
        while (end_of_startup_out !== 1'b1 && n < 40) begin
            @(posedge mclk_in);
            #1 n++;
        end
        `CHK(n inside {[9:14]}, 1'b1)
        $display("test startup done");
        konst = $urandom;
        acc(1'b1, ADDR_CONST, konst);
        acc(1'b0, ADDR_CONST, konst);
        acc(1'b0, ADDR_STATUS, 32'h0000_0001);
        acc(1'b0, 8'h10, READ_ZERO);
        @(posedge mclk_in) ce_in <= 1'b0;
        acc(1'b1, ADDR_CONST, ~konst);
        ce_in <= 1'b1;
        acc(1'b1, 8'h10, ~konst);
        acc(1'b1, ADDR_CTRL, 32'h0000_0001);
        acc(1'b0, ADDR_CTRL, 32'h0000_0001);
        acc(1'b0, ADDR_CONST, konst);
        `CHK(fabric_word_out, konst)
        $display("test registers done");
        acc(1'b1, ADDR_CTRL, 32'h0000_0000);
        prom.tail(3);
        prom.send($urandom, 12);
        prom.tail(1);
        for (int i = 0; i < 3; i++) begin
            w = $urandom;
            exp_q.push_back(w);
            prom.send(w, WORD_W);
        end
        prom.tail(2);
        repeat (8) @(posedge mclk_in);
        `CHK(exp_q.size(), 0)
        acc(1'b0, ADDR_WORD, w);
        acc(1'b0, ADDR_STATUS, 32'h0000_0303);
        acc(1'b1, ADDR_STATUS, READ_ZERO);
        acc(1'b0, ADDR_STATUS, 32'h0000_0301);
        `CHK(fabric_word_out, w)
        $display("test stream done");
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_in);
            {user_cfg_clock_out_in, user_cfg_clock_tristate_in} <= i[3:2];
            {user_done_out_in, user_done_tristate_in} <= i[1:0];
            repeat (2) @(posedge mclk_in);
            #1 `CHK({configuration_clock_pin_out, configuration_clock_pin_oe_n_out}, i[3:2])
            `CHK({done_pin_out, done_pin_oe_n_out}, i[1:0])
        end
        $display("test overrides done");
        @(posedge mclk_in);
        global_set_reset_in <= 1'b1;
        global_tristate_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1 `CHK({fabric_word_out, global_set_reset_out}, {WORD_INIT, 1'b1})
        `CHK(global_tristate_out, 1'b1)
        acc(1'b0, ADDR_WORD, WORD_INIT);
        @(posedge mclk_in);
        global_set_reset_in <= 1'b0;
        global_tristate_in <= 1'b0;
        $display("test global controls done");
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            @(posedge mclk_in);
            test_clock_pin_in <= w[1];
            serial_data_pin_in <= w[0];
            repeat (4) @(posedge mclk_in);
            #1 `CHK({test_clock_tap_out, serial_in_tap_out}, w[1:0])
        end
        `CHK(cfg_oscillator_clock_out, cfg_oscillator_clock_in)
        `CHK(cfg_main_clock_out, mclk_in)
        $display("test taps done");
        complete_run();
    end
endmodule : tb
